// file: core/bptg_pkg.sv
`default_nettype none
package bptg_pkg;
  // ==========================================
  // Timebase
  localparam int unsigned CLK_HZ    = 40_000_000;
  localparam int unsigned REF_HZ    = 10_000_000;
  localparam int unsigned TICK_DIV  = CLK_HZ / REF_HZ;
  localparam logic [1:0]  TICK_LAST = 2'(TICK_DIV - 1);
  localparam int          COUNT_W   = 34;

  // ==========================================
  // Register word indices (byte address = 4 * index)
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_DELAY  = 3'h1;
  localparam logic [2:0] REG_BURST  = 3'h2;
  localparam logic [2:0] REG_PULSE  = 3'h3;
  localparam logic [2:0] REG_PERIOD = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // ==========================================
  // Field positions and reset values
  localparam int         CTL_MAN     = 8;
  localparam int         SET_DIG_LSB = 0;
  localparam int         SET_RNG_LSB = 16;
  localparam logic [4:0] CTRL_RST    = 5'h02;
  localparam logic [3:0] RNG_SPECIAL = 4'h0;

  // ==========================================
  // Types
  typedef struct packed {
    logic [3:0] rng;
    logic [9:0] dig;
  } bptg_set_t;

  typedef struct packed {
    logic marker_src;
    logic square;
    logic two_phase;
    logic edge_rise;
    logic cont;
  } bptg_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DELAY = 2'h1,
    ST_BURST = 2'h3,
    ST_DEAD  = 2'h2
  } bptg_state_t;

  // Reference ticks per unit digit for each range code
  function automatic logic [23:0] base_ticks(input logic [3:0] rng);
    case (rng)
      4'h1:    base_ticks = 24'h000001;
      4'h2:    base_ticks = 24'h00000A;
      4'h3:    base_ticks = 24'h000064;
      4'h4:    base_ticks = 24'h0003E8;
      4'h5:    base_ticks = 24'h002710;
      4'h6:    base_ticks = 24'h0186A0;
      4'h7:    base_ticks = 24'h0F4240;
      4'h8:    base_ticks = 24'h989680;
      default: base_ticks = 24'h000000;
    endcase
  endfunction : base_ticks
endpackage : bptg_pkg
`default_nettype wire

// file: core/bptg_core.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Trigger edge polarity follows edge select
// - Continuous mode restarts cycle at once
// - Manual request starts one cycle now
// - Otherwise only valid trigger starts cycle
// - Cycle indicator spans start to burst end
// - Trigger and manual starts recognised only while gate high; continuous mode starts regardless of gate
// - Triggers ignored while response unfinished
// - Each time is range times digits
// - Timing derived from divided 10 MHz
// - Delay precedes burst; zero when none
// - Single or short window gives one pulse
// - Started pulse always runs full length
// - Pulses repeat each period within window
// - Half period mode sets pulse length
// - Period spaces starts of adjacent pulses
// - Dead time of one period after burst, none in continuous mode
// - Flag inconsistent settings as conflict
// - Burst marker shows window or delay
// - Pulse marker follows pulse timing
// - Two phase doubles pulse with negative half
// - Square mode suppresses baseline during window
// - Pulse indicator high while pulse runs
// - Settings take effect from next cycle
// - Two phase needs period above twice length
module bptg_core #(
  parameter int COUNT_W = bptg_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // External start
  input  wire logic        trig,
  input  wire logic        gate,
  // Indicators and markers
  output logic             cycle_active_indicator,
  output logic             pulse_active_indicator,
  output logic             pulse_marker_output,
  output logic             burst_marker_output,
  output logic             setting_conflict_flag,
  output logic             negative_phase,
  output logic             baseline_suppress
);

  // ==========================================
  // Timebase
  logic [1:0] div_r;
  wire        tick = (div_r == bptg_pkg::TICK_LAST);

  always_ff @(posedge clk) begin
    if (!rstn) div_r <= 2'h0;
    else div_r <= tick ? 2'h0 : 2'(div_r + 2'h1);
  end

  // ==========================================
  // Register bus
  logic                  wait_r;
  logic [31:0]           rdata_r;
  bptg_pkg::bptg_ctrl_t  ctrl_r;
  bptg_pkg::bptg_set_t   dly_r;
  bptg_pkg::bptg_set_t   bst_r;
  bptg_pkg::bptg_set_t   pls_r;
  bptg_pkg::bptg_set_t   per_r;
  logic                  man_r;
  bptg_pkg::bptg_state_t st_r;
  logic                  cyc_r;
  logic                  pact_r;
  logic                  bmk_r;
  logic                  conf_r;
  logic                  neg_r;
  logic                  supp_r;

  wire                   acc    = (avs_read | avs_write) & wait_r;
  wire                   wr_en  = avs_write & ~wait_r;
  wire                   wr_ctl = wr_en & (avs_address == bptg_pkg::REG_CTRL);
  wire bptg_pkg::bptg_set_t wset = {avs_writedata[bptg_pkg::SET_RNG_LSB +: 4],
                                    avs_writedata[bptg_pkg::SET_DIG_LSB +: 10]};

  function automatic logic [31:0] set_word(input bptg_pkg::bptg_set_t s);
    set_word = {12'h000, s.rng, 6'h00, s.dig};
  endfunction : set_word

  wire [31:0] rd_w =
    (avs_address == bptg_pkg::REG_CTRL)   ? {27'h0000000, ctrl_r} :
    (avs_address == bptg_pkg::REG_DELAY)  ? set_word(dly_r) :
    (avs_address == bptg_pkg::REG_BURST)  ? set_word(bst_r) :
    (avs_address == bptg_pkg::REG_PULSE)  ? set_word(pls_r) :
    (avs_address == bptg_pkg::REG_PERIOD) ? set_word(per_r) :
    (avs_address == bptg_pkg::REG_STATUS) ? {26'h0000000, st_r, bmk_r, conf_r, pact_r, cyc_r} :
    32'h00000000;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h00000000;
      man_r   <= 1'b0;
    end else begin
      wait_r  <= ~acc;
      rdata_r <= acc ? rd_w : rdata_r;
      man_r   <= wr_ctl & avs_writedata[bptg_pkg::CTL_MAN];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_r <= bptg_pkg::CTRL_RST;
      dly_r  <= 14'h0000;
      bst_r  <= 14'h0000;
      pls_r  <= 14'h0000;
      per_r  <= 14'h0000;
    end else if (wr_en) begin
      if (avs_address == bptg_pkg::REG_CTRL) ctrl_r <= avs_writedata[4:0];
      if (avs_address == bptg_pkg::REG_DELAY) dly_r <= wset;
      if (avs_address == bptg_pkg::REG_BURST) bst_r <= wset;
      if (avs_address == bptg_pkg::REG_PULSE) pls_r <= wset;
      if (avs_address == bptg_pkg::REG_PERIOD) per_r <= wset;
    end
  end

  // ==========================================
  // Input synchronisers and edge detect
  logic [2:0] trig_s_r;
  logic [1:0] gate_s_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      trig_s_r <= {3{trig}};
      gate_s_r <= 2'h3;
    end else begin
      trig_s_r <= {trig_s_r[1:0], trig};
      gate_s_r <= {gate_s_r[0], gate};
    end
  end

  wire gate_s   = gate_s_r[1];
  wire trig_evt = ctrl_r.edge_rise ? (trig_s_r[1] & ~trig_s_r[2])
                                   : (~trig_s_r[1] & trig_s_r[2]);

  // ==========================================
  // Live timing values
  function automatic logic [COUNT_W-1:0] tval(input bptg_pkg::bptg_set_t s);
    tval = COUNT_W'(s.dig) * COUNT_W'(bptg_pkg::base_ticks(s.rng));
  endfunction : tval

  wire [COUNT_W-1:0] dly_v  = tval(dly_r);
  wire [COUNT_W-1:0] bst_v  = tval(bst_r);
  wire [COUNT_W-1:0] per_v  = tval(per_r);
  wire [COUNT_W-1:0] plen_v = (pls_r.rng == bptg_pkg::RNG_SPECIAL) ? (per_v >> 1) : tval(pls_r);
  wire [COUNT_W:0]   pl2_v  = {plen_v, 1'b0};
  wire               one_v  = (bst_r.rng == bptg_pkg::RNG_SPECIAL) | (bst_v < plen_v);
  wire               conf_w = (plen_v == {COUNT_W{1'b0}}) | (per_v < plen_v)
                            | (ctrl_r.two_phase & ({1'b0, per_v} <= pl2_v));

  // ==========================================
  // Cycle sequencer
  logic [COUNT_W-1:0] cnt_r;
  logic [COUNT_W-1:0] perc_r;
  logic [COUNT_W:0]   pc_r;
  logic               pon_r;
  logic               win_r;
  logic [COUNT_W-1:0] d_l;
  logic [COUNT_W-1:0] b_l;
  logic [COUNT_W-1:0] pl_l;
  logic [COUNT_W-1:0] per_l;
  logic               one_l;
  logic               two_l;
  logic               sq_l;
  logic               msrc_l;

  wire               idle     = (st_r == bptg_pkg::ST_IDLE);
  wire               in_burst = (st_r == bptg_pkg::ST_BURST);
  wire [COUNT_W:0]   cnt1     = (COUNT_W+1)'(cnt_r) + (COUNT_W+1)'(1);
  wire [COUNT_W:0]   perc1    = (COUNT_W+1)'(perc_r) + (COUNT_W+1)'(1);
  wire [COUNT_W:0]   pc1      = pc_r + (COUNT_W+1)'(1);
  wire [COUNT_W:0]   pe_w     = two_l ? {pl_l, 1'b0} : {1'b0, pl_l};
  wire               pc_done  = pon_r & (pc1 >= pe_w);
  wire               win_end  = cnt1 >= {1'b0, b_l};
  wire               re_pulse = ~one_l & win_r & ~win_end & (perc1 >= {1'b0, per_l});
  wire               pon_t    = re_pulse | (pon_r & ~pc_done);
  wire               win_t    = win_r & ~win_end;
  wire               b_fin    = in_burst & tick & ~win_t & ~pon_t;
  wire               start_w  = idle & (ctrl_r.cont | (gate_s & (man_r | trig_evt)));
  wire               new_cyc  = start_w | (b_fin & ctrl_r.cont);
  wire               dly_fin  = (st_r == bptg_pkg::ST_DELAY) & tick & (cnt1 >= {1'b0, d_l});
  wire               dead_fin = (st_r == bptg_pkg::ST_DEAD) & tick & (cnt1 >= {1'b0, per_l});
  wire               go_burst = (new_cyc & (dly_v == {COUNT_W{1'b0}})) | dly_fin;
  wire               go_delay = new_cyc & (dly_v != {COUNT_W{1'b0}});
  wire               pls_new  = go_burst | (in_burst & tick & re_pulse);

  wire bptg_pkg::bptg_state_t st_nxt =
    go_burst ? bptg_pkg::ST_BURST :
    go_delay ? bptg_pkg::ST_DELAY :
    b_fin    ? bptg_pkg::ST_DEAD  :
    dead_fin ? bptg_pkg::ST_IDLE  : st_r;

  wire [COUNT_W-1:0] cnt_nxt  = (go_burst | go_delay | b_fin) ? {COUNT_W{1'b0}} :
                                (tick & ~idle) ? cnt1[COUNT_W-1:0] : cnt_r;
  wire [COUNT_W-1:0] perc_nxt = pls_new ? {COUNT_W{1'b0}} :
                                (tick & in_burst) ? perc1[COUNT_W-1:0] : perc_r;
  wire [COUNT_W:0]   pc_nxt   = pls_new ? {(COUNT_W+1){1'b0}} :
                                (tick & pon_r) ? pc1 : pc_r;
  wire               pon_nxt  = go_burst | (in_burst & (tick ? pon_t : pon_r));
  wire               win_nxt  = go_burst | (in_burst & (tick ? win_t : win_r));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r   <= bptg_pkg::ST_IDLE;
      cnt_r  <= {COUNT_W{1'b0}};
      perc_r <= {COUNT_W{1'b0}};
      pc_r   <= {(COUNT_W+1){1'b0}};
      pon_r  <= 1'b0;
      win_r  <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      perc_r <= perc_nxt;
      pc_r   <= pc_nxt;
      pon_r  <= pon_nxt;
      win_r  <= win_nxt;
    end
  end

  // Settings captured at cycle start
  always_ff @(posedge clk) begin
    if (!rstn) begin
      d_l    <= {COUNT_W{1'b0}};
      b_l    <= {COUNT_W{1'b0}};
      pl_l   <= {COUNT_W{1'b0}};
      per_l  <= {COUNT_W{1'b0}};
      one_l  <= 1'b1;
      two_l  <= 1'b0;
      sq_l   <= 1'b0;
      msrc_l <= 1'b0;
    end else if (new_cyc) begin
      d_l    <= dly_v;
      b_l    <= bst_v;
      pl_l   <= plen_v;
      per_l  <= per_v;
      one_l  <= one_v;
      two_l  <= ctrl_r.two_phase;
      sq_l   <= ctrl_r.square;
      msrc_l <= ctrl_r.marker_src;
    end
  end

  // ==========================================
  // Registered outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cyc_r  <= 1'b0;
      pact_r <= 1'b0;
      bmk_r  <= 1'b0;
      conf_r <= 1'b0;
      neg_r  <= 1'b0;
      supp_r <= 1'b0;
    end else begin
      cyc_r  <= (st_r == bptg_pkg::ST_DELAY) | in_burst;
      pact_r <= in_burst & pon_r;
      bmk_r  <= msrc_l ? (st_r == bptg_pkg::ST_DELAY) : (in_burst & win_r);
      conf_r <= conf_w;
      neg_r  <= in_burst & pon_r & two_l & (pc_r >= {1'b0, pl_l});
      supp_r <= in_burst & win_r & sq_l;
    end
  end

  assign avs_readdata           = rdata_r;
  assign avs_waitrequest        = wait_r;
  assign cycle_active_indicator = cyc_r;
  assign pulse_active_indicator = pact_r;
  assign pulse_marker_output    = pact_r;
  assign burst_marker_output    = bmk_r;
  assign setting_conflict_flag  = conf_r;
  assign negative_phase         = neg_r;
  assign baseline_suppress      = supp_r;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_idle_start;
    idle && start_w;
  endsequence

  sequence s_burst_on;
    in_burst && pon_r;
  endsequence

  a_edge_trig_start: assert property (
    idle && !ctrl_r.cont && gate_s && (trig_s_r[1] != trig_s_r[2]) && (trig_s_r[1] == ctrl_r.edge_rise)
    |=> !idle) else $error("valid trigger edge did not start a cycle");
  a_cont_restart: assert property (
    b_fin && ctrl_r.cont |=> (st_r == bptg_pkg::ST_DELAY) || in_burst)
    else $error("continuous mode did not restart");
  a_manual_go: assert property (
    idle && man_r && gate_s |=> !idle) else $error("manual request ignored");
  a_cycle_ind: assert property (
    (st_r == bptg_pkg::ST_DELAY) ##1 (st_r == bptg_pkg::ST_DELAY) |-> cycle_active_indicator)
    else $error("cycle indicator low during cycle");
  a_gate_block: assert property (
    idle && !gate_s && !ctrl_r.cont |=> idle) else $error("start recognised with gate low");
  a_busy_ignore: assert property (
    (st_r == bptg_pkg::ST_DELAY) && !dly_fin |=> st_r == bptg_pkg::ST_DELAY)
    else $error("delay disturbed by trigger");
  a_dead_time: assert property (
    (st_r == bptg_pkg::ST_DEAD) |=> (st_r == bptg_pkg::ST_DEAD) || idle)
    else $error("dead time skipped");
  a_zero_delay: assert property (
    s_idle_start ##0 (dly_v == {COUNT_W{1'b0}}) |=> in_burst) else $error("zero delay not skipped");
  a_single_pulse: assert property (
    in_burst && one_l && !pon_r && !new_cyc |=> !pon_r) else $error("extra pulse in single mode");
  a_pulse_full: assert property (
    s_burst_on ##0 !(tick && pc_done) |=> pon_r) else $error("pulse cut short");
  a_repeat_pulse: assert property (
    in_burst && tick && re_pulse |=> pon_r && (pc_r == {(COUNT_W+1){1'b0}}))
    else $error("period restart missing");
  a_conflict_two: assert property (
    ctrl_r.two_phase && ({1'b0, per_v} <= pl2_v) |=> setting_conflict_flag)
    else $error("two phase conflict not flagged");
  a_marker_src: assert property (
    (st_r == bptg_pkg::ST_DELAY) |=> burst_marker_output == msrc_l) else $error("burst marker wrong");
  a_pulse_ind: assert property (
    s_burst_on |=> pulse_active_indicator && pulse_marker_output) else $error("pulse indicator low");
  a_square_supp: assert property (
    in_burst && win_r && sq_l |=> baseline_suppress) else $error("baseline not suppressed");
  a_sync_once: assert property (
    trig_evt |=> !trig_evt) else $error("one edge gave two events");
  a_bus_wait: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait request low for two cycles");
  a_dead_hold: assert property (
    (st_r == bptg_pkg::ST_DEAD) && !dead_fin |=> st_r == bptg_pkg::ST_DEAD) else $error("dead time cut short");
  a_settings_hold: assert property (
    !new_cyc |=> $stable(b_l) && $stable(pl_l) && $stable(per_l)) else $error("settings changed mid cycle");
  a_neg_phase: assert property (
    s_burst_on ##0 two_l && (pc_r >= {1'b0, pl_l}) |=> negative_phase) else $error("negative phase missing");

endmodule : bptg_core
`default_nettype wire

// file: bench/bptg_far.sv
`timescale 1ns/100ps
`default_nettype none
module bptg_far (
  // Clock
  input  wire logic clk,
  // Commands from the bench
  input  wire logic flip_req,
  input  wire logic gate_drive,
  input  wire logic gate_level,
  // Lines into the generator
  output logic      trig,
  output logic      gate
);
  // ==========
  // Trigger line
  logic trig_r;
  initial trig_r = 1'b0;
  always @(posedge clk) begin
    if (flip_req) begin
      trig_r <= ~trig_r;
    end
  end
  assign trig = trig_r;
  // ==========
  // Gate line, pulled up when left open
  assign gate = gate_drive ? gate_level : 1'b1;
endmodule : bptg_far
`default_nettype wire

// file: bench/burst_pulse_timing_generator_test.sv
`timescale 1ns/100ps
`default_nettype none
module burst_pulse_timing_generator_test;
  // ==========
  // Signals
  logic        clk, rstn, avs_read, avs_write, flip_req, gate_drive, gate_level;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        avs_waitrequest, trig, gate, ca, pa, pm, bm, cf, np, bs;
  logic [4:0]  q;
  wire  [4:0]  v = {~ca, pa, np, bm, bs};
  int          bad_count, checked, cyc, ncyc, npul, pt, dl, pi, rc, k, d, b, l, p;
  int          rt[5], wd[5];

  bptg_core u_bptg_core (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .trig(trig), .gate(gate), .cycle_active_indicator(ca),
    .pulse_active_indicator(pa), .pulse_marker_output(pm), .burst_marker_output(bm),
    .setting_conflict_flag(cf), .negative_phase(np), .baseline_suppress(bs));
  bptg_far u_bptg_far (.clk(clk), .flip_req(flip_req), .gate_drive(gate_drive),
    .gate_level(gate_level), .trig(trig), .gate(gate));

  always #12.5 clk = ~clk;
  // ==========
  // Tasks
  task automatic close_out();
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic near(input int a, input int x);
    return (a >= x - 5) && (a <= x + 5);
  endfunction : near
  function automatic logic [31:0] tv(input int dg);
    return 32'h10000 | 32'(dg);
  endfunction : tv
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] dt);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= dt;
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  task automatic cfg(input logic [31:0] c, dv, bv, lv, pv);
    repeat (220) @(posedge clk);
    bus(1'b1, bptg_pkg::REG_CTRL, c);
    bus(1'b1, bptg_pkg::REG_DELAY, dv);
    bus(1'b1, bptg_pkg::REG_BURST, bv);
    bus(1'b1, bptg_pkg::REG_PULSE, lv);
    bus(1'b1, bptg_pkg::REG_PERIOD, pv);
    repeat (3) @(posedge clk);
  endtask : cfg
  task automatic flip();
    @(posedge clk);
    flip_req <= 1'b1;
    @(posedge clk);
    flip_req <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : flip
  task automatic run_chk(input int dd, bb, ll, pp, input bit sg, tp);
    int ne;
    while (ca !== 1'b1) begin
      @(posedge clk);
    end
    while (ca !== 1'b0) begin
      @(posedge clk);
    end
    repeat (2) @(posedge clk);
    ne = (sg || bb < ll) ? 1 : (bb - 1) / pp + 1;
    chk(npul, ne);
    chk(near(wd[3], (tp ? 8 : 4) * ll), 1'b1);
    chk(near(dl, 4 * dd), 1'b1);
    if (ne > 1) chk(near(pi, 4 * pp), 1'b1);
    if (tp) chk(near(wd[2], 4 * ll), 1'b1);
  endtask : run_chk
  // ==========
  // Monitor
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      close_out();
    end
    chk(pm, pa);
    if (ca === 1'b1 && q[4] === 1'b1) begin
      ncyc++;
      npul = 0;
      rc = cyc;
    end
    if (pa === 1'b1 && q[3] === 1'b0) begin
      if (npul == 0) dl = cyc - rc;
      else pi = cyc - rt[3];
      npul++;
      pt++;
    end
    for (int i = 0; i < 5; i++) begin
      if (v[i] === 1'b1 && q[i] === 1'b0) rt[i] = cyc;
      if (v[i] === 1'b0 && q[i] === 1'b1) wd[i] = cyc - rt[i];
    end
    q = v;
  end
  // ==========
  // Main sequence
  initial begin
    clk = 0; rstn = 0; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
    flip_req = 0; gate_drive = 0; gate_level = 1; q = 0;
    void'($urandom(32'h3550));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk({ca, pa, bm, np, bs}, 5'h00);
    repeat (2) @(posedge clk);
    chk(cf, 1'b1);
    bus(1'b0, bptg_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, 3'h6, 32'hFFFF);
    bus(1'b0, 3'h6, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 3; i++) begin
      cfg(i == 2 ? 32'h6 : 32'h2, 0, tv(12), tv(i == 0 ? 6 : 3), tv(i == 0 ? 5 : 6));
      chk(cf, i != 1);
    end
    cfg(32'h2, tv(3), tv(12), tv(3), tv(5));
    bus(1'b0, bptg_pkg::REG_DELAY, 32'h0);
    chk(rd, tv(3));
    flip();
    run_chk(3, 12, 3, 5, 0, 0);
    repeat (40) @(posedge clk);
    k = ncyc;
    flip();
    repeat (20) @(posedge clk);
    chk(ncyc, k);
    cfg(32'h2, tv(3), tv(12), tv(3), tv(50));
    flip();
    flip();
    flip();
    run_chk(3, 12, 3, 50, 0, 0);
    flip();
    flip();
    repeat (30) @(posedge clk);
    chk(ncyc, k + 1);
    repeat (220) @(posedge clk);
    flip();
    flip();
    run_chk(3, 12, 3, 50, 0, 0);
    chk(ncyc, k + 2);
    chk(wd[4] >= 200, 1'b1);
    cfg(32'h0, tv(3), tv(12), tv(3), tv(5));
    flip();
    run_chk(3, 12, 3, 5, 0, 0);
    gate_drive <= 1'b1;
    gate_level <= 1'b0;
    repeat (40) @(posedge clk);
    k = ncyc;
    flip();
    flip();
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h100);
    repeat (50) @(posedge clk);
    chk(ncyc, k);
    gate_drive <= 1'b0;
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h102);
    run_chk(3, 12, 3, 5, 0, 0);
    bus(1'b0, bptg_pkg::REG_CTRL, 32'h0);
    chk(rd, 32'h2);
    cfg(32'h2, tv(0), 32'd12, tv(3), tv(8));
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h102);
    run_chk(0, 12, 3, 8, 1, 0);
    cfg(32'h2, 32'd5, tv(2), tv(5), tv(8));
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h102);
    run_chk(0, 2, 5, 8, 0, 0);
    cfg(32'h2, tv(2), tv(20), 32'd7, tv(8));
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h102);
    run_chk(2, 20, 4, 8, 0, 0);
    cfg(32'h6, tv(2), tv(12), tv(2), tv(5));
    bus(1'b1, bptg_pkg::REG_CTRL, 32'h106);
    run_chk(2, 12, 2, 5, 0, 1);
    for (int i = 0; i < 2; i++) begin
      cfg(i ? 32'h12 : 32'h0A, tv(3), tv(12), tv(3), tv(5));
      bus(1'b1, bptg_pkg::REG_CTRL, i ? 32'h112 : 32'h10A);
      run_chk(3, 12, 3, 5, 0, 0);
      chk(near(wd[1], i ? 12 : 48), 1'b1);
      if (!i) chk(near(wd[0], 48), 1'b1);
    end
    for (int i = 0; i < 3; i++) begin
      l = 1 + $urandom % 4;
      p = l + 1 + $urandom % 4;
      b = 1 + $urandom % 20;
      d = $urandom % 4;
      cfg(32'h2, tv(d), tv(b), tv(l), tv(p));
      chk(cf, 1'b0);
      if (trig === 1'b1) flip();
      flip();
      run_chk(d, b, l, p, 0, 0);
    end
    cfg(32'h3, tv(3), tv(12), tv(3), tv(5));
    k = pt;
    repeat (1024) @(posedge clk);
    chk(pt - k >= 42 && pt - k <= 51, 1'b1);
    close_out();
  end
endmodule : burst_pulse_timing_generator_test
`default_nettype wire
